// File: rtl/strap_cfg_map.vh
/*
 * constants for the strap capture and bring-up block: strap encodings,
 * reset values, protocol codes and the start-up delay.
 * assumes inclusion by bare name from the rtl files.
 */
`ifndef STRAP_CFG_MAP_VH
`define STRAP_CFG_MAP_VH

// protocol select codes {hi, lo}
`define PROTO_MACPHY_PROT 2'h0
`define PROTO_MACPHY_PLAIN 2'h1
`define PROTO_GENERIC_CRC 2'h2
`define PROTO_GENERIC_PLAIN 2'h3

// resolved role codes
`define ROLE_SLAVE 2'h0
`define ROLE_MASTER 2'h1
`define ROLE_FAULT 2'h2

// identity value, arbitrary and neutral
`define CHIP_IDENTITY_VALUE 32'h0A5C0DE1

// start-up time before the ready flag rises, in ns, and its cycle count at 5 ns
`define STARTUP_TIME_NS 200
`define CLK_PERIOD_NS 5
`define STARTUP_CYCLES ((`STARTUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STARTUP_CNT_W 8

// reset values of control state
`define AN_ENABLE_RST 1'b1
`define CFG_DONE_RST 1'b0
`define RESET_COMPLETE_RST 1'b1

`endif

// File: rtl/strap_latch.v
/*
 * strap_latch: catches the configuration straps once after each reset
 * release and holds them until the next reset.
 * assumes straps are synchronous to the clock and stable at the release.
 */
`timescale 1ns/100ps
`include "strap_cfg_map.vh"

module strap_latch (
    input wire clk_in,
    input wire rst_in,
    input wire [4:0] straps_in,
    output reg [4:0] straps_out,
    output reg valid_out
);

    // --------------------------------------------------------------
    // capture once after release
    // --------------------------------------------------------------
    // the asynchronous reset loads constants only; the pins are taken
    // on the first edge after release, then frozen so shared pins can
    // go back to their main use
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            straps_out <= 5'h00;
            valid_out <= 1'b0;
        end else if (!valid_out) begin
            straps_out <= straps_in;
            valid_out <= 1'b1;
        end
    end

endmodule

// File: rtl/role_resolver.v
/*
 * role_resolver: registered master/slave outcome from local and partner
 * advertisements, or straight from the preference when negotiation is off.
 * assumes partner bits are valid while done_in is high.
 */
`timescale 1ns/100ps
`include "strap_cfg_map.vh"

module role_resolver (
    input wire clk_in,
    input wire rst_in,
    input wire an_enable_in,
    input wire done_in,
    input wire loc_force_in,
    input wire loc_master_in,
    input wire lp_force_in,
    input wire lp_master_in,
    input wire coin_in,
    output reg [1:0] role_out
);

    // --------------------------------------------------------------
    // resolution function
    // --------------------------------------------------------------
    function [1:0] resolve;
        input lf;
        input lm;
        input rf;
        input rm;
        input coin;
        begin
            if (lf && rf)
                resolve = (lm == rm) ? `ROLE_FAULT : (lm ? `ROLE_MASTER : `ROLE_SLAVE);
            else if (lf)
                resolve = lm ? `ROLE_MASTER : `ROLE_SLAVE;
            else if (rf)
                resolve = rm ? `ROLE_SLAVE : `ROLE_MASTER;
            else if (lm != rm)
                resolve = lm ? `ROLE_MASTER : `ROLE_SLAVE;
            else
                resolve = coin ? `ROLE_MASTER : `ROLE_SLAVE;
        end
    endfunction

    // --------------------------------------------------------------
    // registered role
    // --------------------------------------------------------------
    // without negotiation the role is the preference itself
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            role_out <= `ROLE_SLAVE;
        end else if (!an_enable_in) begin
            role_out <= loc_master_in ? `ROLE_MASTER : `ROLE_SLAVE;
        end else if (done_in) begin
            role_out <= resolve(loc_force_in, loc_master_in, lp_force_in, lp_master_in, coin_in);
        end
    end

endmodule

// File: rtl/strap_config_and_bringup.v
/*
 * strap_config_and_bringup: strap capture, power-down control, reset
 * complete and interrupt summary flags, identity and bring-up status.
 * assumes a host drives the control strobes one clock wide, synchronous
 * to CLOCK_IN; RST_IN covers power-on, hardware and software reset.
 * straps must be settled before RST_IN falls and for one edge after it;
 * after that first edge the pins are free for their main functions.
 * negotiation itself lives outside; this block only starts it and
 * turns the partner's advertisement into a role once it is done.
 * the tie-break is a toggle, not random; it only splits equal choices.
 * writes that arrive before the defaults are loaded are lost, except the reset-complete clear and config-done strobes.
 */
`timescale 1ns/100ps
`include "strap_cfg_map.vh"

module strap_config_and_bringup (
    // clock and reset
    input wire CLOCK_IN,
    input wire RST_IN,
    // straps, read once after each reset
    input wire STRAP_ROLE_PREFERENCE_IN,
    input wire STRAP_TX_LEVEL_LIMIT_IN,
    input wire STRAP_PROTOCOL_SELECT_HI_IN,
    input wire STRAP_PROTOCOL_SELECT_LO_IN,
    input wire STRAP_POWERDOWN_AFTER_RESET_IN,
    // supply and capability levels
    input wire HIGH_ANALOG_SUPPLY_IN,
    input wire HIGH_LEVEL_CAPABLE_IN,
    // host field writes, one clock wide
    input wire ADV_HIGH_WR_IN,
    input wire ADV_HIGH_DATA_IN,
    input wire ROLE_WR_IN,
    input wire ROLE_FORCE_DATA_IN,
    input wire ROLE_MASTER_DATA_IN,
    input wire AN_ENABLE_WR_IN,
    input wire AN_ENABLE_DATA_IN,
    input wire POWERDOWN_WR_IN,
    input wire POWERDOWN_DATA_IN,
    input wire RESET_COMPLETE_CLR_IN,
    input wire CFG_DONE_WR_IN,
    input wire CFG_DONE_DATA_IN,
    // interrupt causes and masks, 1 = masked
    input wire SUBSYSTEM_IRQ_STATUS_IN,
    input wire SYSMGR_IRQ_STATUS_IN,
    input wire SUBSYSTEM_IRQ_MASK_IN,
    input wire SYSMGR_IRQ_MASK_IN,
    // negotiation outcome from the link side
    input wire AN_DONE_IN,
    input wire LP_FORCE_IN,
    input wire LP_MASTER_IN,
    // identity and configuration fields
    output reg [31:0] CHIP_IDENTITY_OUT,
    output reg [1:0] PROTOCOL_SELECT_OUT,
    output reg ROLE_PREF_MASTER_OUT,
    output reg ROLE_FORCE_OUT,
    output reg ADV_HIGH_LEVEL_SUPPORT_OUT,
    output reg HIGH_LEVEL_OFFERED_OUT,
    output reg AN_ENABLE_OUT,
    // sequence and status flags
    output reg AN_START_OUT,
    output reg POWERDOWN_REQUEST_OUT,
    output reg POWERDOWN_STATE_OUT,
    output reg SYSTEM_READY_OUT,
    output reg RESET_COMPLETE_OUT,
    output reg PHY_IRQ_SUMMARY_OUT,
    output reg CFG_DONE_OUT,
    output reg NOT_RESET_SEEN_OUT,
    output reg IRQ_OUT,
    // resolved role: slave, master or fault
    output reg [1:0] ROLE_OUT
);

    // --------------------------------------------------------------
    // states of the bring-up sequence (one-hot)
    // --------------------------------------------------------------
    // one-hot codes: each state is a single flop, decode is one bit
    localparam [3:0] ST_CAPTURE = 4'h1;
    localparam [3:0] ST_STARTUP = 4'h2;
    localparam [3:0] ST_POWERDOWN = 4'h4;
    localparam [3:0] ST_ACTIVE = 4'h8;

    // the count is compared against its last value, so the start-up
    // phase lasts exactly the start-up cycle count
    localparam integer startup_last_i = `STARTUP_CYCLES - 1;
    localparam [`STARTUP_CNT_W-1:0] startup_last = startup_last_i[`STARTUP_CNT_W-1:0];

    // sequence state and start-up count
    reg [3:0] state_q;
    reg [3:0] state_d;
    reg [`STARTUP_CNT_W-1:0] cnt_q;
    // free-running tie-break toggle
    reg coin_q;
    // set once strap defaults sit in the fields; writes count from then on
    reg defaults_loaded_q;

    // strap bits in order {pd, hi, lo, level, role}
    wire [4:0] straps_raw;
    wire [4:0] straps;
    wire straps_valid;
    wire [1:0] role_res;
    wire level_locked;
    wire pd_release;

    assign straps_raw = {STRAP_POWERDOWN_AFTER_RESET_IN, STRAP_PROTOCOL_SELECT_HI_IN,
                         STRAP_PROTOCOL_SELECT_LO_IN, STRAP_TX_LEVEL_LIMIT_IN,
                         STRAP_ROLE_PREFERENCE_IN};

    // --------------------------------------------------------------
    // strap capture
    // --------------------------------------------------------------
    strap_latch u_latch (
        .clk_in(CLOCK_IN),
        .rst_in(RST_IN),
        .straps_in(straps_raw),
        .straps_out(straps),
        .valid_out(straps_valid)
    );

    // level strap high locks out high-level advertisement
    assign level_locked = straps[1];

    // falling request releases power-down
    // only a 1 -> 0 change counts; a repeated 0 write does nothing
    assign pd_release = POWERDOWN_WR_IN && !POWERDOWN_DATA_IN && POWERDOWN_REQUEST_OUT;

    // --------------------------------------------------------------
    // master/slave resolution
    // --------------------------------------------------------------
    // the fault code passes through unchanged; a failed negotiation
    // leaves the role at fault until the next completion or until negotiation is switched off
    role_resolver u_resolver (
        .clk_in(CLOCK_IN),
        .rst_in(RST_IN),
        .an_enable_in(AN_ENABLE_OUT),
        .done_in(AN_DONE_IN),
        .loc_force_in(ROLE_FORCE_OUT),
        .loc_master_in(ROLE_PREF_MASTER_OUT),
        .lp_force_in(LP_FORCE_IN),
        .lp_master_in(LP_MASTER_IN),
        .coin_in(coin_q),
        .role_out(role_res)
    );

    // --------------------------------------------------------------
    // sequence next state
    // --------------------------------------------------------------
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_CAPTURE: begin
                // wait for the one-edge strap capture
                if (straps_valid)
                    state_d = ST_STARTUP;
            end
            ST_STARTUP: begin
                // count out start-up, then branch on the power-down strap
                if (cnt_q == startup_last)
                    state_d = straps[4] ? ST_ACTIVE : ST_POWERDOWN;
            end
            ST_POWERDOWN: begin
                // held here until the host drops the request
                if (pd_release)
                    state_d = ST_ACTIVE;
            end
            ST_ACTIVE: begin
                // a request written high sends the block back to power-down
                if (POWERDOWN_WR_IN && POWERDOWN_DATA_IN)
                    state_d = ST_POWERDOWN;
            end
            // an illegal code falls back to the capture state; the held straps pass it straight on
            default: state_d = ST_CAPTURE;
        endcase
    end

    // --------------------------------------------------------------
    // sequence state, start-up counter and tie-break bit
    // --------------------------------------------------------------
    // the tie-break toggles freely; a cheap stand-in for a random source
    always @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_q <= ST_CAPTURE;
            cnt_q <= {`STARTUP_CNT_W{1'b0}};
            coin_q <= 1'b0;
        end else begin
            state_q <= state_d;
            coin_q <= ~coin_q;
            // the counter stops once the state moves on, so it never wraps
            if (state_q == ST_STARTUP)
                cnt_q <= cnt_q + 1'b1;
        end
    end

    // --------------------------------------------------------------
    // configuration fields with strap defaults
    // --------------------------------------------------------------
    // defaults load one cycle after capture; software writes win later
    always @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            defaults_loaded_q <= 1'b0;
            ROLE_PREF_MASTER_OUT <= 1'b0;
            // no strap for the force bit: it always starts as a preference
            ROLE_FORCE_OUT <= 1'b0;
            ADV_HIGH_LEVEL_SUPPORT_OUT <= 1'b0;
            PROTOCOL_SELECT_OUT <= `PROTO_MACPHY_PROT;
            AN_ENABLE_OUT <= `AN_ENABLE_RST;
            POWERDOWN_REQUEST_OUT <= 1'b0;
        end else if (straps_valid && !defaults_loaded_q) begin
            defaults_loaded_q <= 1'b1;
            ROLE_PREF_MASTER_OUT <= straps[0];
            ADV_HIGH_LEVEL_SUPPORT_OUT <= !straps[1] && HIGH_LEVEL_CAPABLE_IN;
            // the protocol code is fixed from here until the next reset
            PROTOCOL_SELECT_OUT <= straps[3:2];
            POWERDOWN_REQUEST_OUT <= !straps[4];
        end else if (defaults_loaded_q) begin
            if (ROLE_WR_IN) begin
                ROLE_FORCE_OUT <= ROLE_FORCE_DATA_IN;
                ROLE_PREF_MASTER_OUT <= ROLE_MASTER_DATA_IN;
            end
            // writes ignored while strapped low-level only; without capability a write clears the bit
            if (ADV_HIGH_WR_IN && !level_locked)
                ADV_HIGH_LEVEL_SUPPORT_OUT <= ADV_HIGH_DATA_IN && HIGH_LEVEL_CAPABLE_IN;
            // negotiation off hands the role straight to the preference
            if (AN_ENABLE_WR_IN)
                AN_ENABLE_OUT <= AN_ENABLE_DATA_IN;
            // the sequence decides what a power-down write means in each state
            if (POWERDOWN_WR_IN)
                POWERDOWN_REQUEST_OUT <= POWERDOWN_DATA_IN;
        end
    end

    // --------------------------------------------------------------
    // status flags and outputs
    // --------------------------------------------------------------
    always @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            CHIP_IDENTITY_OUT <= 32'h00000000;
            HIGH_LEVEL_OFFERED_OUT <= 1'b0;
            AN_START_OUT <= 1'b0;
            POWERDOWN_STATE_OUT <= 1'b1;
            SYSTEM_READY_OUT <= 1'b0;
            RESET_COMPLETE_OUT <= `RESET_COMPLETE_RST;
            PHY_IRQ_SUMMARY_OUT <= 1'b0;
            CFG_DONE_OUT <= `CFG_DONE_RST;
            NOT_RESET_SEEN_OUT <= 1'b0;
            IRQ_OUT <= 1'b0;
            ROLE_OUT <= `ROLE_SLAVE;
        end else begin
            // identity readable once the sequence is under way
            CHIP_IDENTITY_OUT <= (state_q != ST_CAPTURE) ? `CHIP_IDENTITY_VALUE : 32'h00000000;

            // offered only with capability, supply and advertisement together
            HIGH_LEVEL_OFFERED_OUT <= HIGH_LEVEL_CAPABLE_IN && HIGH_ANALOG_SUPPLY_IN &&
                                      ADV_HIGH_LEVEL_SUPPORT_OUT;
            // one pulse on every entry into active operation while negotiation is enabled
            AN_START_OUT <= (state_d == ST_ACTIVE) && (state_q != ST_ACTIVE) && AN_ENABLE_OUT;
            // follows the next state, so it drops with the start pulse
            POWERDOWN_STATE_OUT <= (state_d != ST_ACTIVE);
            // ready once start-up has run out, in either end state
            SYSTEM_READY_OUT <= (state_q == ST_POWERDOWN) || (state_q == ST_ACTIVE);

            // one-shot flag: only a new reset sets it again
            if (RESET_COMPLETE_CLR_IN)
                RESET_COMPLETE_OUT <= 1'b0;
            // no hardware re-set source exists after reset, so no set/clear race
            PHY_IRQ_SUMMARY_OUT <= (SUBSYSTEM_IRQ_STATUS_IN && !SUBSYSTEM_IRQ_MASK_IN) ||
                                   (SYSMGR_IRQ_STATUS_IN && !SYSMGR_IRQ_MASK_IN);
            // pin goes high (inactive) once the reset-complete source is cleared
            IRQ_OUT <= !(RESET_COMPLETE_OUT && !RESET_COMPLETE_CLR_IN);

            // host-written completion mark, kept across host restarts
            if (CFG_DONE_WR_IN)
                CFG_DONE_OUT <= CFG_DONE_DATA_IN;
            // configured but not reset: the host restarted on its own
            NOT_RESET_SEEN_OUT <= !RESET_COMPLETE_OUT && CFG_DONE_OUT;
            // registered again so the port comes straight from a flop
            ROLE_OUT <= role_res;
        end
    end

endmodule

// File: testbench/strap_config_and_bringup_props.sv
/* checker: port relations of strap_config_and_bringup.
   assumes one clock and an async active-high reset; bound below. */
`timescale 1ns/100ps
`include "strap_cfg_map.vh"
module strap_config_and_bringup_props (
    input wire CLOCK_IN,
    input wire RST_IN,
    input wire RESET_COMPLETE_CLR_IN,
    input wire SUBSYSTEM_IRQ_STATUS_IN,
    input wire SYSMGR_IRQ_STATUS_IN,
    input wire SUBSYSTEM_IRQ_MASK_IN,
    input wire SYSMGR_IRQ_MASK_IN,
    input wire HIGH_LEVEL_CAPABLE_IN,
    input wire HIGH_ANALOG_SUPPLY_IN,
    input wire POWERDOWN_WR_IN,
    input wire POWERDOWN_DATA_IN,
    input wire [31:0] CHIP_IDENTITY_OUT,
    input wire HIGH_LEVEL_OFFERED_OUT,
    input wire AN_ENABLE_OUT,
    input wire AN_START_OUT,
    input wire POWERDOWN_REQUEST_OUT,
    input wire POWERDOWN_STATE_OUT,
    input wire SYSTEM_READY_OUT,
    input wire RESET_COMPLETE_OUT,
    input wire PHY_IRQ_SUMMARY_OUT,
    input wire CFG_DONE_OUT,
    input wire NOT_RESET_SEEN_OUT,
    input wire IRQ_OUT
);
// ----------------------------------------
// cycle count since release
// ----------------------------------------
reg [7:0] cyc_q;
wire armed = cyc_q >= 8'h02;
// saturates so a long run never wraps back into the start-up window
always @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN)
        cyc_q <= 8'h00;
    else if (cyc_q != 8'hFF)
        cyc_q <= cyc_q + 8'h01;
end
default clocking cb @(posedge CLOCK_IN); endclocking
default disable iff (RST_IN);
a_rc_clear_irq: assert property (armed && RESET_COMPLETE_CLR_IN |=> !RESET_COMPLETE_OUT && IRQ_OUT)
    else $error("reset-complete clear not honoured");
a_rc_falls_cause: assert property ($fell(RESET_COMPLETE_OUT) |-> $past(RESET_COMPLETE_CLR_IN))
    else $error("reset-complete fell without a clear");
a_summary_lag: assert property (armed |-> PHY_IRQ_SUMMARY_OUT == $past((SUBSYSTEM_IRQ_STATUS_IN
    && !SUBSYSTEM_IRQ_MASK_IN) || (SYSMGR_IRQ_STATUS_IN && !SYSMGR_IRQ_MASK_IN)))
    else $error("interrupt summary wrong");
a_not_reset_seen: assert property (armed
    |-> NOT_RESET_SEEN_OUT == $past(!RESET_COMPLETE_OUT && CFG_DONE_OUT))
    else $error("not-reset flag wrong");
a_offer_needs_cap: assert property (HIGH_LEVEL_OFFERED_OUT
    |-> $past(HIGH_LEVEL_CAPABLE_IN && HIGH_ANALOG_SUPPLY_IN))
    else $error("high level offered without capability");
a_pd_release_start: assert property (armed && SYSTEM_READY_OUT && POWERDOWN_STATE_OUT
    && POWERDOWN_REQUEST_OUT && AN_ENABLE_OUT && POWERDOWN_WR_IN && !POWERDOWN_DATA_IN
    |=> !POWERDOWN_STATE_OUT && AN_START_OUT ##1 !AN_START_OUT)
    else $error("power-down release did not start negotiation");
a_start_one_cycle: assert property (AN_START_OUT |-> !POWERDOWN_STATE_OUT ##1 !AN_START_OUT)
    else $error("start pulse wrong");
a_ready_time: assert property ($rose(SYSTEM_READY_OUT) |-> cyc_q >= 8'd40 && cyc_q <= 8'd44)
    else $error("ready rose at the wrong time");
a_id_valid: assert property (cyc_q >= 8'h03 |-> CHIP_IDENTITY_OUT == `CHIP_IDENTITY_VALUE)
    else $error("identity value wrong");
a_reset_values: assert property ($fell(RST_IN) |-> AN_ENABLE_OUT && RESET_COMPLETE_OUT && POWERDOWN_STATE_OUT)
    else $error("reset values wrong");
c_clear: cover property (armed && RESET_COMPLETE_CLR_IN);
c_ready: cover property ($rose(SYSTEM_READY_OUT));
c_start: cover property (AN_START_OUT);
endmodule
bind strap_config_and_bringup strap_config_and_bringup_props i_props (.*);

// File: testbench/host_ctrl_model.sv
/* host controller model: one-cycle write strobes and interrupt masks.
   assumes the bench calls its tasks just after a clock edge. */
`timescale 1ns/100ps
module host_ctrl_model (
    input wire clk_in,
    input wire [31:0] id_in,
    input wire rc_in,
    output reg [5:0] wr_out,
    output reg [1:0] d_out,
    output reg [1:0] mask_out
);
initial begin
    wr_out = 6'h00;
    d_out = 2'h0;
    mask_out = 2'h0;
end
// strobe k high for exactly one edge; data inverted once released
task put(input integer k, input [1:0] d);
    begin
        wr_out[k] = 1'b1;
        d_out = d;
        @(posedge clk_in);
        #1;
        wr_out = 6'h00;
        d_out = ~d;
    end
endtask
task set_masks(input [1:0] m);
    mask_out = m;
endtask
// identity and reset-complete checked, then masks, then config done
task bring_up(input [31:0] id_exp, input [1:0] m, output ok);
    begin
        ok = (id_in === id_exp) && (rc_in === 1'b1);
        mask_out = m;
        put(5, 2'h1);
    end
endtask
endmodule

// File: testbench/test_strap_config_and_bringup.sv
/* bench: every strap pattern through reset, bring-up writes, role outcome
   and a random interrupt run. assumes the host model and bound checker. */
`timescale 1ns/100ps
`include "strap_cfg_map.vh"
module test_strap_config_and_bringup;
logic CLOCK_IN, RST_IN, HIGH_ANALOG_SUPPLY_IN, HIGH_LEVEL_CAPABLE_IN, AN_DONE_IN, LP_FORCE_IN, LP_MASTER_IN;
logic SUBSYSTEM_IRQ_STATUS_IN, SYSMGR_IRQ_STATUS_IN;
logic [4:0] st;
logic [31:0] r;
wire [5:0] wr;
wire [1:0] d, mk;
wire [31:0] CHIP_IDENTITY_OUT;
wire [1:0] PROTOCOL_SELECT_OUT, ROLE_OUT;
wire ROLE_PREF_MASTER_OUT, ROLE_FORCE_OUT, ADV_HIGH_LEVEL_SUPPORT_OUT, HIGH_LEVEL_OFFERED_OUT, AN_ENABLE_OUT;
wire AN_START_OUT, POWERDOWN_REQUEST_OUT, POWERDOWN_STATE_OUT, SYSTEM_READY_OUT, RESET_COMPLETE_OUT;
wire PHY_IRQ_SUMMARY_OUT, CFG_DONE_OUT, NOT_RESET_SEEN_OUT, IRQ_OUT;
// straps {pd, hi, lo, level, role}; host strobes 0 adv 1 role 2 an 3 pd 4 clr 5 cfg
wire STRAP_ROLE_PREFERENCE_IN = st[0], STRAP_TX_LEVEL_LIMIT_IN = st[1];
wire STRAP_PROTOCOL_SELECT_LO_IN = st[2], STRAP_PROTOCOL_SELECT_HI_IN = st[3];
wire STRAP_POWERDOWN_AFTER_RESET_IN = st[4];
wire ADV_HIGH_WR_IN = wr[0], ROLE_WR_IN = wr[1], AN_ENABLE_WR_IN = wr[2], POWERDOWN_WR_IN = wr[3];
wire RESET_COMPLETE_CLR_IN = wr[4], CFG_DONE_WR_IN = wr[5];
wire ADV_HIGH_DATA_IN = d[0], ROLE_FORCE_DATA_IN = d[1], ROLE_MASTER_DATA_IN = d[0];
wire AN_ENABLE_DATA_IN = d[0], POWERDOWN_DATA_IN = d[0], CFG_DONE_DATA_IN = d[0];
wire SUBSYSTEM_IRQ_MASK_IN = mk[0], SYSMGR_IRQ_MASK_IN = mk[1];
integer fail_count = 0, samples_checked = 0, seed = 86861, cyc = 0, i;
strap_config_and_bringup i_dut (.*);
host_ctrl_model i_host (.clk_in(CLOCK_IN), .id_in(CHIP_IDENTITY_OUT), .rc_in(RESET_COMPLETE_OUT),
    .wr_out(wr), .d_out(d), .mask_out(mk));
initial begin
    CLOCK_IN = 1'b0;
    forever #2.5 CLOCK_IN = ~CLOCK_IN;
end
// ----------------------------------------
// checking and verdict
// ----------------------------------------
task give_verdict;
    begin
        if (fail_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    end
endtask
task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    end
endtask
function logic exp_sum(input logic [3:0] v);
    exp_sum = (v[0] && !v[2]) || (v[1] && !v[3]);
endfunction
// a hang is cut short well past the expected run length
always @(posedge CLOCK_IN) begin
    cyc = cyc + 1;
    if (cyc == 12000) begin
        fail_count = fail_count + 1;
        give_verdict;
    end
end
task tick(input integer k);
    begin
        repeat (k) @(posedge CLOCK_IN);
        #1;
    end
endtask
// one reset with strap pattern p, then the bring-up sequence
task run_pattern(input logic [4:0] p);
    integer n, starts;
    logic ok, c, s;
    begin
        st = p;
        RST_IN = 1'b1;
        AN_DONE_IN = 1'b0;
        HIGH_LEVEL_CAPABLE_IN = 1'b1;
        tick(5);
        RST_IN = 1'b0;
        tick(3);
        r = $random(seed);
        st = r[4:0]; // pins go back to their main use
        chk(PROTOCOL_SELECT_OUT, p[3:2]);
        chk(ROLE_PREF_MASTER_OUT, p[0]);
        chk(ADV_HIGH_LEVEL_SUPPORT_OUT, !p[1]);
        chk(POWERDOWN_REQUEST_OUT, !p[4]);
        chk({AN_ENABLE_OUT, POWERDOWN_STATE_OUT, RESET_COMPLETE_OUT, IRQ_OUT}, 4'hE);
        chk(CHIP_IDENTITY_OUT, `CHIP_IDENTITY_VALUE);
        n = 0;
        starts = 0;
        while (SYSTEM_READY_OUT !== 1'b1 && n < 60) begin
            tick(1);
            n = n + 1;
            starts = starts + AN_START_OUT;
        end
        repeat (3) begin
            tick(1);
            starts = starts + AN_START_OUT;
        end
        chk(n >= 37 && n < 60, 1);
        chk(POWERDOWN_STATE_OUT, !p[4]);
        chk(starts, p[4]);
        chk(PROTOCOL_SELECT_OUT, p[3:2]);
        c = r[5];
        s = r[6];
        HIGH_LEVEL_CAPABLE_IN = c;
        HIGH_ANALOG_SUPPLY_IN = s;
        i_host.put(0, 2'h1);
        tick(1);
        chk(ADV_HIGH_LEVEL_SUPPORT_OUT, !p[1] && c);
        chk(HIGH_LEVEL_OFFERED_OUT, !p[1] && c && s);
        if (!p[4]) begin
            i_host.put(3, 2'h0);
            chk({POWERDOWN_STATE_OUT, AN_START_OUT}, 2'h1);
        end
        LP_FORCE_IN = r[7];
        LP_MASTER_IN = !p[0];
        AN_DONE_IN = 1'b1;
        tick(3);
        chk(ROLE_OUT, {1'b0, p[0]});
        i_host.bring_up(`CHIP_IDENTITY_VALUE, r[9:8], ok);
        chk(ok, 1);
        chk(CFG_DONE_OUT, 1);
        tick(1);
        i_host.put(4, 2'h0);
        chk({RESET_COMPLETE_OUT, IRQ_OUT}, 2'h1);
        tick(1);
        chk(NOT_RESET_SEEN_OUT, 1);
        i_host.put(2, 2'h0);
        LP_FORCE_IN = 1'b1;
        LP_MASTER_IN = p[0];
        tick(3);
        chk(ROLE_OUT, {1'b0, p[0]});
        i_host.put(1, {1'b1, !p[0]});
        chk({ROLE_FORCE_OUT, ROLE_PREF_MASTER_OUT}, {1'b1, !p[0]});
        tick(2);
        chk(ROLE_OUT, {1'b0, !p[0]});
    end
endtask
// ----------------------------------------
// main sequence
// ----------------------------------------
initial begin
    RST_IN = 1'b1;
    st = 5'h00;
    {HIGH_ANALOG_SUPPLY_IN, HIGH_LEVEL_CAPABLE_IN, AN_DONE_IN, LP_FORCE_IN, LP_MASTER_IN} = 5'h00;
    {SUBSYSTEM_IRQ_STATUS_IN, SYSMGR_IRQ_STATUS_IN} = 2'h0;
    tick(1);
    for (i = 0; i < 32; i = i + 1) begin
        run_pattern(i[4:0]);
    end
    // random statuses and masks; summary lags its cause by one edge
    r = 32'h0;
    repeat (200) begin
        chk(PHY_IRQ_SUMMARY_OUT, exp_sum({mk, SYSMGR_IRQ_STATUS_IN, SUBSYSTEM_IRQ_STATUS_IN}));
        r = $random(seed);
        {SYSMGR_IRQ_STATUS_IN, SUBSYSTEM_IRQ_STATUS_IN} = r[1:0];
        i_host.set_masks(r[3:2]);
        tick(1);
    end
    give_verdict;
end
endmodule
